// ===== hdl/vcsd_pkg.sv
// Shared constants and types of the video clock select and divider
package vcsd_pkg;
	// Register indices on the device's own register port
	localparam logic [3:0] REG_GEN_CTL = 4'h8;
	localparam logic [3:0] REG_IN_SEL  = 4'h9;
	localparam logic [3:0] REG_OUT_SEL = 4'hA;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	// Reset values: first oscillator, video clock high, shift clock low
	localparam logic [7:0] IN_SEL_RST  = 8'h00;
	localparam logic [7:0] OUT_SEL_RST = 8'h36;
	localparam logic [7:0] GEN_CTL_RST = 8'h00;
	// Field positions
	localparam int SPLIT_EN_BIT = 2;
	localparam int VID_DIV_LSB  = 3;
	localparam int SHF_DIV_LSB  = 0;
	localparam logic [7:0] CNT_CLR_MASK = 8'h36;
	// Source select codes
	localparam logic [3:0] SRC_CODE_A    = 4'h0;
	localparam logic [3:0] SRC_CODE_B    = 4'h1;
	localparam logic [3:0] SRC_CODE_C    = 4'h2;
	localparam logic [3:0] SRC_CODE_D    = 4'h3;
	localparam logic [3:0] SRC_CODE_D2   = 4'h4;
	localparam logic [3:0] SRC_CODE_DIFF = 4'h8;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SETTLE_NS     = 30;
	localparam int PULSE_NS      = 15;
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Source switch sequencer
	typedef enum logic [2:0]
	{
		SW_IDLE   = 3'b001,
		SW_DRAIN  = 3'b010,
		SW_SETTLE = 3'b100
	} vcsd_sw_t;
endpackage

// ===== hdl/vcsd_link_if.sv
// Link between the clock device and the raster controller
`timescale 1ns/100ps
interface vcsd_link_if;
	logic [3:0] regAddr;
	logic [7:0] regWdata;
	logic       regWr;
	logic       regRd;
	logic [7:0] regRdata;
	logic       swReset;
	logic       oscHold;
	logic       rasterCtrlClockOut;
	logic       shiftClk;
	logic       blankN;
	logic       splitNibbleFlagIn;
	modport dev
	(
		input  regAddr,
		input  regWdata,
		input  regWr,
		input  regRd,
		output regRdata,
		input  swReset,
		input  oscHold,
		output rasterCtrlClockOut,
		output shiftClk,
		input  blankN,
		input  splitNibbleFlagIn
	);
	modport host
	(
		output regAddr,
		output regWdata,
		output regWr,
		output regRd,
		input  regRdata,
		output swReset,
		output oscHold,
		input  rasterCtrlClockOut,
		input  shiftClk,
		output blankN,
		output splitNibbleFlagIn
	);
endinterface

// ===== hdl/vcsd_device.sv
// Dot clock source select, shared divider and blank-gated shift clock
//
// Contract
// RULE1: Low nibble code picks dot clock source
// RULE2: Upper input select nibble ignored
// RULE3: First oscillator is source after reset
// RULE4: New clocks settle 30 ns after change
// RULE5: Bits 5..3 divide video clock, 11 holds high
// RULE6: Bits 2..0 divide shift clock, 11 holds low
// RULE7: One shared counter drives both clocks
// RULE8: Bits 5,4,2,1 all set clear counter
// RULE9: All resets load defaults, clear counter
// RULE10: System stops dot clock during counter clear; the clear pattern loaded by reset leaves it running
// RULE11: Pixels captured on ungated load clock
// RULE12: Host picks shift divide for bus width
// RULE13: Blank sampled on video falling, gates shift
// RULE14: High shift clock finishes before being held
// RULE15: Blank delayed to align with pixel data
// RULE16: Host reloads shift register during blanking
// RULE17: Split flag rise gives one replacing pulse
// RULE18: Control bit 2 enables split handling
// RULE19: Video clock defaults to steady high
// RULE20: Raster logic needs video clock enabled
// RULE21: Source switching passes no runt pulses
`timescale 1ns/100ps
module vcsd_device #(
	parameter int BLANK_DLY = 2
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       oscInputA,
	input  wire logic       oscInputB,
	input  wire logic       oscInputC,
	input  wire logic       oscInputDDualMode,
	input  wire logic       oscDiffN,
	input  wire logic [7:0] pixelIn,
	output logic      [7:0] pixelOut,
	output logic            blankAligned,
	output logic            pixelRateClock,
	vcsd_link_if.dev        link
);
	typedef struct packed {
		logic [7:0]           inSel;
		logic [7:0]           outSel;
		logic [7:0]           genCtl;
		logic [7:0]           rdData;
		logic [3:0]           srcCur;
		logic [3:0]           srcReq;
		vcsd_pkg::vcsd_sw_t   sw;
		logic [1:0]           settle;
		logic                 prevDot;
		logic [4:0]           cnt;
		logic                 videoOut;
		logic                 shiftOut;
		logic                 loadClk;
		logic                 blankSmp;
		logic                 gateOpen;
		logic                 skip;
		logic                 splitPrev;
		logic [1:0]           pulse;
		logic [7:0]           pixel;
		logic [BLANK_DLY-1:0] blankPipe;
	} vcsd_dev_t;

	vcsd_dev_t st;
	vcsd_dev_t next_st;

	// Level of the oscillator named by a source code; unknown codes give low
	function automatic logic srcLevel(input logic [3:0] code);
		unique case (code)
			vcsd_pkg::SRC_CODE_A:    srcLevel = oscInputA;
			vcsd_pkg::SRC_CODE_B:    srcLevel = oscInputB;
			vcsd_pkg::SRC_CODE_C:    srcLevel = oscInputC;
			vcsd_pkg::SRC_CODE_D,
			vcsd_pkg::SRC_CODE_D2:   srcLevel = oscInputDDualMode;
			vcsd_pkg::SRC_CODE_DIFF: srcLevel = oscInputDDualMode & ~oscDiffN;
			default:                 srcLevel = 1'b0;
		endcase
	endfunction

	// Legal source codes; anything else keeps the present source
	function automatic logic srcValid(input logic [3:0] code);
		srcValid = (code <= vcsd_pkg::SRC_CODE_D2) || (code == vcsd_pkg::SRC_CODE_DIFF);
	endfunction

	// Divide by 2**k taken from the shared counter, k = 0 is the dot level
	function automatic logic divClk(input logic [2:0] k, input logic [4:0] c, input logic d);
		if (k == 3'h0)
			divClk = d;
		else
			divClk = ~c[k - 3'h1];
	endfunction

	logic dotLevel;
	logic dotTick;
	logic videoRaw;
	logic shiftRaw;
	logic shiftFall;

	always_comb
	begin
		next_st = st;
		dotLevel = 1'b0;
		dotTick = 1'b0;
		videoRaw = 1'b1;
		shiftRaw = 1'b0;
		shiftFall = 1'b0;
		// Register writes and reads, read data one cycle later
		next_st.rdData = 8'h00;
		if (link.regWr)
		begin
			unique case (link.regAddr)
				vcsd_pkg::REG_GEN_CTL: next_st.genCtl = link.regWdata; // see RULE18
				vcsd_pkg::REG_IN_SEL:  next_st.inSel = link.regWdata;
				vcsd_pkg::REG_OUT_SEL: next_st.outSel = link.regWdata;
				default:               next_st.genCtl = st.genCtl;
			endcase
		end
		if (link.regRd)
		begin
			unique case (link.regAddr)
				vcsd_pkg::REG_GEN_CTL: next_st.rdData = st.genCtl;
				vcsd_pkg::REG_IN_SEL:  next_st.rdData = st.inSel;
				vcsd_pkg::REG_OUT_SEL: next_st.rdData = st.outSel;
				vcsd_pkg::REG_STATUS:
					next_st.rdData = {st.sw != vcsd_pkg::SW_IDLE, st.gateOpen, st.blankSmp,
						st.skip, st.srcCur};
				default:               next_st.rdData = 8'h00;
			endcase
		end
		// Software reset restores the defaults like the hardware reset
		if (link.swReset)
		begin
			next_st.inSel = vcsd_pkg::IN_SEL_RST;   // see RULE9
			next_st.outSel = vcsd_pkg::OUT_SEL_RST;
			next_st.genCtl = vcsd_pkg::GEN_CTL_RST;
		end
		// Source switch: freeze, wait until both sources are low, then settle
		next_st.srcReq = st.inSel[3:0];                // see RULE2
		unique case (st.sw)
			vcsd_pkg::SW_IDLE:
				if (srcValid(st.srcReq) && st.srcReq != st.srcCur) // see RULE1
					next_st.sw = vcsd_pkg::SW_DRAIN;
			vcsd_pkg::SW_DRAIN:
				if (!srcLevel(st.srcCur) && !srcLevel(st.srcReq)) // see RULE21
				begin
					next_st.sw = vcsd_pkg::SW_SETTLE;
					next_st.settle = 2'(vcsd_pkg::SETTLE_CYC); // see RULE4
				end
			vcsd_pkg::SW_SETTLE:
				if (st.settle <= 2'h1)
				begin
					next_st.sw = vcsd_pkg::SW_IDLE;
					if (srcValid(st.srcReq))
						next_st.srcCur = st.srcReq;
				end
				else
					next_st.settle = st.settle - 2'h1;
		endcase
		// Dot clock held low while switching, so no runt reaches the counter
		dotLevel = (st.sw == vcsd_pkg::SW_IDLE) && srcLevel(st.srcCur) && !link.oscHold; // see RULE21
		dotTick = dotLevel && !st.prevDot;
		next_st.prevDot = dotLevel;
		// Shared counter, cleared while the hold pattern is written
		if ((st.outSel & vcsd_pkg::CNT_CLR_MASK) == vcsd_pkg::CNT_CLR_MASK || link.swReset)
			next_st.cnt = 5'h00;                   // see RULE8
		else if (dotTick)
			next_st.cnt = st.cnt + 5'h01;          // see RULE7
		// Video clock: codes 6 and 7 hold it high; next count keeps every rise on a dot rise
		if (st.outSel[5:4] != 2'b11) // see RULE5 RULE7
			videoRaw = divClk(st.outSel[vcsd_pkg::VID_DIV_LSB +: 3], next_st.cnt, dotLevel);
		// Shift clock: codes 6 and 7 hold it low
		if (st.outSel[2:1] != 2'b11) // see RULE6 RULE7
			shiftRaw = divClk(st.outSel[vcsd_pkg::SHF_DIV_LSB +: 3], next_st.cnt, dotLevel);
		next_st.videoOut = videoRaw;
		next_st.loadClk = shiftRaw;
		shiftFall = st.loadClk && !shiftRaw;
		// Blank taken on the falling edge of the video clock
		if (st.videoOut && !videoRaw)
			next_st.blankSmp = link.blankN;        // see RULE13
		// Skipped pulse counted once blanking ends
		if (st.blankSmp && shiftFall)
			next_st.skip = 1'b0;
		// Split flag rise: one pulse that replaces the first gated one
		next_st.splitPrev = link.splitNibbleFlagIn;
		if (st.pulse != 2'h0)
			next_st.pulse = st.pulse - 2'h1;
		if (st.genCtl[vcsd_pkg::SPLIT_EN_BIT] && link.splitNibbleFlagIn && !st.splitPrev)
		begin
			next_st.pulse = 2'(vcsd_pkg::PULSE_CYC); // see RULE17
			next_st.skip = 1'b1;                   // set wins over clear
		end
		// Gate only changes while the shift clock is low, so it never cuts a pulse
		if (!shiftRaw)
			next_st.gateOpen = st.blankSmp && !next_st.skip; // see RULE14
		next_st.shiftOut = (next_st.gateOpen && shiftRaw) || (next_st.pulse != 2'h0);
		// Pixel capture on the ungated load clock, blank delayed alongside
		if (shiftRaw && !st.loadClk)
		begin
			next_st.pixel = pixelIn;               // see RULE11
			next_st.blankPipe = {st.blankPipe[BLANK_DLY-2:0], st.blankSmp}; // see RULE15
		end
	end

	// All state in one register, defaults on reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.inSel <= vcsd_pkg::IN_SEL_RST;      // see RULE3
			st.outSel <= vcsd_pkg::OUT_SEL_RST;    // see RULE19
			st.genCtl <= vcsd_pkg::GEN_CTL_RST;
			st.srcCur <= vcsd_pkg::SRC_CODE_A;
			st.srcReq <= vcsd_pkg::SRC_CODE_A;
			st.sw <= vcsd_pkg::SW_IDLE;
			st.videoOut <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign link.regRdata = st.rdData;
	assign link.rasterCtrlClockOut = st.videoOut;
	assign link.shiftClk = st.shiftOut;
	assign pixelOut = st.pixel;
	assign blankAligned = st.blankPipe[BLANK_DLY-1];
	assign pixelRateClock = st.prevDot;
endmodule

// ===== hdl/vcsd_raster_host.sv
// Raster controller end: register master, blank, syncs and split flag
`timescale 1ns/100ps
module vcsd_raster_host #(
	parameter int ACTIVE_CYC = 16,
	parameter int BLANK_CYC  = 8,
	parameter int SYNC_CYC   = 4,
	parameter int LINES      = 8
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [3:0] cmdAddr,
	input  wire logic [7:0] cmdWdata,
	input  wire logic       cmdWr,
	input  wire logic       cmdRd,
	input  wire logic       softReset,
	input  wire logic       splitMode,
	output logic      [7:0] cmdRdata,
	output logic            hsyncN,
	output logic            vsyncN,
	output logic            transferReq,
	vcsd_link_if.host       link
);
	typedef struct packed {
		logic [3:0]  addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
		logic [7:0]  rdata;
		logic        rdPend;
		logic        swReset;
		logic        oscHold;
		logic        prevV;
		logic [15:0] col;
		logic [15:0] line;
		logic        blankN;
		logic        hsyncN;
		logic        vsyncN;
		logic        split;
		logic        xfer;
	} vcsd_host_t;

	vcsd_host_t st;
	vcsd_host_t next_st;
	logic [15:0] nextCol;

	always_comb
	begin
		next_st = st;
		nextCol = st.col;
		// Forward commands; read data reach cmdRdata three cycles after the strobe
		next_st.addr = cmdAddr;
		next_st.wdata = cmdWdata;
		next_st.wr = cmdWr;
		next_st.rd = cmdRd;
		next_st.rdPend = st.rd;
		if (st.rdPend)
			next_st.rdata = link.regRdata;
		next_st.swReset = softReset;
		// Stop the dot clock while a host-written output select holds the counter clear pattern
		if (cmdWr && cmdAddr == vcsd_pkg::REG_OUT_SEL) // see RULE10
			next_st.oscHold = (cmdWdata & vcsd_pkg::CNT_CLR_MASK) == vcsd_pkg::CNT_CLR_MASK;
		// Timing runs on the video clock, so it must be enabled
		next_st.prevV = link.rasterCtrlClockOut;
		next_st.xfer = 1'b0;
		if (link.rasterCtrlClockOut && !st.prevV)  // see RULE20
		begin
			nextCol = (st.col == 16'(ACTIVE_CYC + BLANK_CYC - 1)) ? 16'h0000 : st.col + 16'h0001;
			next_st.col = nextCol;
			if (nextCol == 16'h0000)
				next_st.line = (st.line == 16'(LINES - 1)) ? 16'h0000 : st.line + 16'h0001;
			next_st.blankN = nextCol < 16'(ACTIVE_CYC);
			next_st.hsyncN = !(nextCol >= 16'(ACTIVE_CYC) && nextCol < 16'(ACTIVE_CYC + SYNC_CYC));
			next_st.vsyncN = next_st.line != 16'h0000;
			// Reload request at blank start, split flag rises at its end
			next_st.xfer = nextCol == 16'(ACTIVE_CYC);  // see RULE16
			next_st.split = splitMode && nextCol == 16'(ACTIVE_CYC + BLANK_CYC - 1);
		end
	end

	// All state in one register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.hsyncN <= 1'b1;
			st.vsyncN <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign link.regAddr = st.addr;
	assign link.regWdata = st.wdata;
	assign link.regWr = st.wr;
	assign link.regRd = st.rd;
	assign link.swReset = st.swReset;
	assign link.oscHold = st.oscHold;
	assign link.blankN = st.blankN;
	assign link.splitNibbleFlagIn = st.split;
	assign cmdRdata = st.rdata;
	assign hsyncN = st.hsyncN;
	assign vsyncN = st.vsyncN;
	assign transferReq = st.xfer;
endmodule

// ===== testbench/vcsd_link_properties.sv
// Concurrent checks on the link between the clock device and the raster controller
`timescale 1ns/100ps
module vcsd_link_properties (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	input  wire logic [7:0] regRdata,
	input  wire logic       swReset,
	input  wire logic       oscHold,
	input  wire logic       rasterCtrlClockOut,
	input  wire logic       shiftClk,
	input  wire logic       blankN,
	input  wire logic       splitNibbleFlagIn
);
	logic [7:0] inSel;
	logic [7:0] outSel;
	logic [7:0] genCtl;
	logic [1:0] blankFalls;
	logic       holdS;
	logic       holdV;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Shadow registers rebuilt from link traffic, so reads can be judged
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			inSel  <= vcsd_pkg::IN_SEL_RST;
			outSel <= vcsd_pkg::OUT_SEL_RST;
			genCtl <= vcsd_pkg::GEN_CTL_RST;
		end
		else if (swReset)
		begin
			inSel  <= vcsd_pkg::IN_SEL_RST;
			outSel <= vcsd_pkg::OUT_SEL_RST;
			genCtl <= vcsd_pkg::GEN_CTL_RST;
		end
		else if (regWr)
		begin
			if (regAddr == vcsd_pkg::REG_IN_SEL)
				inSel <= regWdata;
			if (regAddr == vcsd_pkg::REG_OUT_SEL)
				outSel <= regWdata;
			if (regAddr == vcsd_pkg::REG_GEN_CTL)
				genCtl <= regWdata;
		end
	end
	// Video falls seen during blank; saturates so a long blank stays counted
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst || blankN)
			blankFalls <= 2'd0;
		else if ($fell(rasterCtrlClockOut) && blankFalls != 2'd3)
			blankFalls <= blankFalls + 2'd1;
	end
	// Hold codes; a split pulse may still override the shift hold
	assign holdS = (outSel[2:1] == 2'b11) && !genCtl[vcsd_pkg::SPLIT_EN_BIT];
	assign holdV = (outSel[5:4] == 2'b11);
	chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data not idle");
	chk_rd_insel: assert property (regRd && regAddr == vcsd_pkg::REG_IN_SEL |=> regRdata == inSel)
		else $error("input select readback wrong");
	chk_rd_outsel: assert property (regRd && regAddr == vcsd_pkg::REG_OUT_SEL |=> regRdata == outSel)
		else $error("output select readback wrong");
	chk_rd_unmapped: assert property (regRd && !(regAddr inside {4'h4, 4'h8, 4'h9, 4'hA}) |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	chk_raster_ctrl_clock_out_hold: assert property (holdV && $past(holdV) && $past(holdV, 2) |-> rasterCtrlClockOut)
		else $error("video clock not held high");
	chk_sclk_hold: assert property (holdS && $past(holdS) && $past(holdS, 2) |-> !shiftClk)
		else $error("shift clock not held low");
	chk_blank_gate: assert property (blankFalls == 2'd3 && !blankN && !genCtl[vcsd_pkg::SPLIT_EN_BIT] |-> !$rose(shiftClk))
		else $error("shift clock rose while blanked");
	chk_split_pulse: assert property (genCtl[vcsd_pkg::SPLIT_EN_BIT] && $rose(splitNibbleFlagIn) |-> ##[1:2] shiftClk)
		else $error("no split pulse");
	chk_swreset_dflt: assert property (swReset |-> ##3 (rasterCtrlClockOut && !shiftClk))
		else $error("soft reset left clocks running");
endmodule

// ===== testbench/testbench.sv
// Self-checking bench joining the clock device and the raster controller
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
	$display("unexpected at %0t ns: got %h want %h", $time, (a), (e)); end end
module testbench;
	logic        sys_clk;
	logic        rst = 1'b1;
	logic [3:0]  cmdAddr = 4'h0;
	logic [7:0]  cmdWdata = 8'h00;
	logic        cmdWr = 1'b0;
	logic        cmdRd = 1'b0;
	logic        softReset = 1'b0;
	logic        splitMode = 1'b0;
	logic [7:0]  cmdRdata;
	logic [7:0]  oscCnt = 8'h00;
	logic [7:0]  pixelIn = 8'h00;
	logic [7:0]  pixelOut;
	logic        pixelRateClock;
	logic        blankAligned;
	logic        hsyncN;
	logic        vsyncN;
	logic        transferReq;
	logic [3:0]  srcExp = 4'h0;
	logic [31:0] seed = 32'h8AFB4908;
	logic [7:0]  rdv;
	logic [2:0]  v;
	logic [2:0]  s;
	logic [3:0]  codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h5};
	int          err_total = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          nV;
	int          nS;
	int          nD;
	int          nLone;
	int          nX;
	int          nH;
	int          nVs;
	int          nB;
	vcsd_link_if vcsd_link_if_inst ();
	wire         videoClk = vcsd_link_if_inst.rasterCtrlClockOut;
	wire         shiftOut = vcsd_link_if_inst.shiftClk;
	vcsd_device vcsd_device_inst (.sys_clk(sys_clk), .rst(rst), .oscInputA(oscCnt[0]),
		.oscInputB(oscCnt[1]), .oscInputC(oscCnt[2]), .oscInputDDualMode(oscCnt[3]),
		.oscDiffN(~oscCnt[3]), .pixelIn(pixelIn), .pixelOut(pixelOut), .blankAligned(blankAligned),
		.pixelRateClock(pixelRateClock), .link(vcsd_link_if_inst));
	vcsd_raster_host vcsd_raster_host_inst (.sys_clk(sys_clk), .rst(rst), .cmdAddr(cmdAddr),
		.cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .softReset(softReset),
		.splitMode(splitMode), .cmdRdata(cmdRdata), .hsyncN(hsyncN), .vsyncN(vsyncN),
		.transferReq(transferReq), .link(vcsd_link_if_inst));
	vcsd_link_properties vcsd_link_properties_inst (.sys_clk(sys_clk), .rst(rst),
		.regAddr(vcsd_link_if_inst.regAddr), .regWdata(vcsd_link_if_inst.regWdata),
		.regWr(vcsd_link_if_inst.regWr), .regRd(vcsd_link_if_inst.regRd),
		.regRdata(vcsd_link_if_inst.regRdata), .swReset(vcsd_link_if_inst.swReset),
		.oscHold(vcsd_link_if_inst.oscHold), .rasterCtrlClockOut(videoClk),
		.shiftClk(shiftOut), .blankN(vcsd_link_if_inst.blankN),
		.splitNibbleFlagIn(vcsd_link_if_inst.splitNibbleFlagIn));
	// Free-running oscillators with periods of 2, 4, 8 and 16 cycles
	always @(posedge sys_clk)
		oscCnt <= oscCnt + 8'h01;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Dot period in cycles; invalid codes keep the previous source
	function automatic int dotPer(input logic [3:0] c);
		dotPer = (c == 4'h0) ? 2 : (c == 4'h1) ? 4 : (c == 4'h2) ? 8 : 16;
	endfunction
	// Edge counts in a window drift by one with phase
	function automatic logic near(input int got, input int want);
		near = (got >= want - 1) && (got <= want + 1);
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cmdAddr <= a;
		cmdWdata <= d;
		cmdWr <= 1'b1;
		@(posedge sys_clk);
		cmdWr <= 1'b0;
	endtask
	// Host returns read data a few cycles late and holds it
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		cmdAddr <= a;
		cmdRd <= 1'b1;
		@(posedge sys_clk);
		cmdRd <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		rdv = cmdRdata;
	endtask
	// Counts rising edges, sync falls and transfer requests; a lone shift rise has no video rise beside it
	task automatic measure(input int n);
		logic pv;
		logic ps;
		logic pd;
		logic ph;
		logic pvs;
		logic pb;
		nV = 0;
		nS = 0;
		nD = 0;
		nLone = 0;
		nX = 0;
		nH = 0;
		nVs = 0;
		nB = 0;
		pv = videoClk;
		ps = shiftOut;
		pd = pixelRateClock;
		ph = hsyncN;
		pvs = vsyncN;
		pb = blankAligned;
		repeat (n)
		begin
			@(negedge sys_clk);
			if (videoClk && !pv)
				nV++;
			if (shiftOut && !ps)
				nS++;
			if (pixelRateClock && !pd)
				nD++;
			if (shiftOut && !ps && !(videoClk && !pv))
				nLone++;
			if (transferReq)
				nX++;
			if (!hsyncN && ph)
				nH++;
			if (!vsyncN && pvs)
				nVs++;
			if (blankAligned && !pb)
				nB++;
			pv = videoClk;
			ps = shiftOut;
			pd = pixelRateClock;
			ph = hsyncN;
			pvs = vsyncN;
			pb = blankAligned;
		end
	endtask
	task automatic check_defaults();
		rd(vcsd_pkg::REG_IN_SEL);
		`CHK(rdv, vcsd_pkg::IN_SEL_RST)
		rd(vcsd_pkg::REG_OUT_SEL);
		`CHK(rdv, vcsd_pkg::OUT_SEL_RST)
		rd(vcsd_pkg::REG_GEN_CTL);
		`CHK(rdv, vcsd_pkg::GEN_CTL_RST)
		`CHK(videoClk, 1'b1)
		`CHK(shiftOut, 1'b0)
		measure(64);
		`CHK(near(nD, 32), 1'b1)
	endtask
	task automatic final_report();
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Ceiling well above the expected run of about 7400 cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			err_total++;
			final_report();
		end
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		check_defaults();
		// Every source code, junk in the upper nibble, then an invalid code
		foreach (codes[i])
		begin
			seed = lfsr(seed);
			wr(vcsd_pkg::REG_IN_SEL, {seed[7:4], codes[i]});
			rd(vcsd_pkg::REG_IN_SEL);
			`CHK(rdv, {seed[7:4], codes[i]})
			measure(64);
			`CHK(near(nD, 64 / dotPer(codes[i])), 1'b1)
			// Only legal codes move the source; others keep the last one
			if (codes[i] <= 4'h4 || codes[i] == 4'h8)
				srcExp = codes[i];
			rd(vcsd_pkg::REG_STATUS);
			`CHK(rdv[3:0], srcExp)
		end
		wr(vcsd_pkg::REG_IN_SEL, 8'h00);
		// All divide codes, ignored top bits random, pixel capture alongside
		for (int t = 0; t < 8; t++)
		begin
			seed = lfsr(seed);
			v = (t < 6) ? 3'(t) : 3'(seed[10:8] % 6);
			s = (t < 6) ? 3'(5 - t) : v;
			pixelIn <= seed[23:16];
			wr(vcsd_pkg::REG_OUT_SEL, {seed[31:30], v, s});
			repeat (16) @(posedge sys_clk);
			measure(512);
			`CHK(near(nV, 256 >> v), 1'b1)
			`CHK(nS <= (256 >> s) + 1, 1'b1)
			if (s >= v)
				`CHK(nLone, 0)
			`CHK(pixelOut, seed[23:16])
		end
		// Clear pattern stops both clocks whatever the other bits hold
		seed = lfsr(seed);
		wr(vcsd_pkg::REG_OUT_SEL, 8'h36 | (seed[7:0] & 8'hC9));
		// Let the old setting drain before counting, a last rise is legal
		repeat (4) @(posedge sys_clk);
		measure(128);
		`CHK(nV + nS, 0)
		`CHK(nD, 0)
		// Split enabled without a flag behaves as plain gating
		wr(vcsd_pkg::REG_GEN_CTL, 8'h04);
		wr(vcsd_pkg::REG_OUT_SEL, 8'h12);
		repeat (16) @(posedge sys_clk);
		measure(600);
		`CHK(nLone, 0)
		splitMode <= 1'b1;
		measure(1600);
		`CHK(nS > 0, 1'b1)
		`CHK(nLone > 0, 1'b1)
		// A line is 24 video periods of 8 cycles with the divide by 4 above
		`CHK(near(nX, 1600 / 192), 1'b1)
		`CHK(near(nH, 1600 / 192), 1'b1)
		`CHK(nVs > 0, 1'b1)
		`CHK(near(nB, 1600 / 192), 1'b1)
		splitMode <= 1'b0;
		// Software reset from a non-default state
		wr(vcsd_pkg::REG_IN_SEL, 8'h01);
		@(posedge sys_clk);
		softReset <= 1'b1;
		@(posedge sys_clk);
		softReset <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check_defaults();
		// Unmapped places read zero and ignore writes
		for (int a = 0; a < 16; a++)
			if (!(a inside {4, 8, 9, 10}))
			begin
				wr(4'(a), 8'hFF);
				rd(4'(a));
				`CHK(rdv, 8'h00)
			end
		rd(vcsd_pkg::REG_OUT_SEL);
		`CHK(rdv, vcsd_pkg::OUT_SEL_RST)
		final_report();
	end
endmodule
